/* srsw_pkg.sv */
package srsw_pkg;

  // release delay and watchdog timeout, printed figures
  localparam int unsigned RELEASE_DELAY_SHORT_MS   = 25;
  localparam int unsigned RELEASE_DELAY_LONG_MS    = 200;
  localparam int unsigned WD_TIMEOUT_SHORT_MS      = 200;
  localparam int unsigned WD_TIMEOUT_LONG_MS       = 1600;
  localparam int unsigned CLK_HZ                   = 25000000;
  localparam int unsigned CYC_PER_MS               = CLK_HZ / 1000;

  // cycle counts derived from times (exact multiples at 25 MHz)
  localparam int unsigned RELEASE_DELAY_SHORT_CYC  =
    RELEASE_DELAY_SHORT_MS * CYC_PER_MS;
  localparam int unsigned RELEASE_DELAY_LONG_CYC   =
    RELEASE_DELAY_LONG_MS * CYC_PER_MS;
  localparam int unsigned WD_TIMEOUT_SHORT_CYC     =
    WD_TIMEOUT_SHORT_MS * CYC_PER_MS;
  localparam int unsigned WD_TIMEOUT_LONG_CYC      =
    WD_TIMEOUT_LONG_MS * CYC_PER_MS;

  localparam int unsigned CNT_W                    = 26;
  localparam logic [CNT_W-1:0] CNT_ZERO            = 26'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE             = 26'h0000001;

  typedef enum logic [1:0] {
    SRSW_ST_HOLD,
    SRSW_ST_DELAY,
    SRSW_ST_RUN
  } srsw_state_type;

  // reset output pin group
  typedef struct packed {
    logic reset_n;
    logic reset_n_oe;
    logic reset_h;
  } srsw_rst_out_type;

endpackage

/* srsw_supervisor.sv */
`timescale 1ns/1ps
// Behaviour
// - reset is asserted from the first moment the logic runs.
// - the active-low reset stays low while supply is below threshold.
// - the active-high reset stays high while supply is below threshold.
// - reset is held for a fixed release delay before going inactive.
// - the release delay counts only while supply is above the rising level.
// - a supply drop re-asserts reset at once and abandons the delay.
// - a low manual reset request asserts reset regardless of all else.
// - the processor must toggle the kick within the watchdog timeout.
// - the manual reset input is a build option, inactive when absent.
// - active-low reset always exists, active-high is its complement.
// - one variant drives reset open-drain, others push-pull.
// - any rising or falling kick edge restarts the watchdog.
// - a watchdog expiry asserts reset for the delay and restarts it.
// - non-revised variants latch reset if kicked during reset.
// - the revised variant ignores kicks during reset.
module srsw_supervisor
  import srsw_pkg::*;
#(
  parameter bit              HAS_MANUAL_RESET = 1'b1,
  parameter bit              HAS_WATCHDOG     = 1'b1,
  parameter bit              HAS_ACTIVE_HIGH  = 1'b0,
  parameter bit              OPEN_DRAIN       = 1'b0,
  parameter bit              REVISED          = 1'b1,
  parameter int unsigned     RELEASE_DELAY_CYC = RELEASE_DELAY_LONG_CYC,
  parameter int unsigned     WD_TIMEOUT_CYC    = WD_TIMEOUT_LONG_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic supply_good_i,
  input  wire logic manual_reset_request_n_i,
  input  wire logic watchdog_kick_input_i,
  output logic      reset_n_o,
  output logic      reset_n_oe_o,
  output logic      reset_o
);

  // last count values, compared against the counters
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(RELEASE_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] WD_LAST    = CNT_W'(WD_TIMEOUT_CYC - 1);

  // local reset release
  logic        rst_meta_reg;
  logic        rst_sync_reg;

  // pin synchronisers and edge detector fill marker
  logic [2:0]  sup_sync_reg;
  logic [2:0]  mr_sync_reg;
  logic [2:0]  wdi_sync_reg;
  logic [2:0]  wdi_fill_reg;

  // sequencer state and counters
  srsw_state_type   state_reg;
  srsw_state_type   state_next;
  logic [CNT_W-1:0] dly_cnt_reg;
  logic [CNT_W-1:0] dly_cnt_next;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [CNT_W-1:0] wd_cnt_next;
  // stuck latch of old parts
  logic             stuck_reg;
  logic             stuck_next;

  // output pin group
  srsw_rst_out_type out_reg;
  srsw_rst_out_type out_next;

  // decoded input levels and events
  logic supply_ok;
  logic mr_active;
  logic kick_edge;
  logic wd_expired;

  // local reset release through two flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // supply-good synchroniser, stage 0 feeds only stage 1
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sup_sync_reg <= 3'h0;
    end else begin
      sup_sync_reg <= {sup_sync_reg[1:0], supply_good_i};
    end
  end

  // manual request resets idle high so reset is not read as a press
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mr_sync_reg <= 3'h7;
    end else begin
      mr_sync_reg <= {mr_sync_reg[1:0], manual_reset_request_n_i};
    end
  end

  // kick synchroniser; the fill marker blocks a false edge after reset,
  // since the pin may idle high while the flops reset low
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wdi_sync_reg <= 3'h0;
      wdi_fill_reg <= 3'h0;
    end else begin
      wdi_sync_reg <= {wdi_sync_reg[1:0], watchdog_kick_input_i};
      wdi_fill_reg <= {wdi_fill_reg[1:0], 1'b1};
    end
  end

  // bit 2 is a delayed copy used only for kick edge detection
  assign supply_ok = sup_sync_reg[1];
  assign mr_active = HAS_MANUAL_RESET && !mr_sync_reg[1];
  assign kick_edge = HAS_WATCHDOG && wdi_fill_reg[2] &&
                     (wdi_sync_reg[1] ^ wdi_sync_reg[2]);
  assign wd_expired = HAS_WATCHDOG && (wd_cnt_reg == WD_LAST);

  // stuck latch: old parts latch on kicks while reset is asserted
  always_comb begin
    stuck_next = stuck_reg;
    if (!REVISED && kick_edge && state_reg != SRSW_ST_RUN) begin
      stuck_next = 1'b1;
    end
  end

  // only power-on reset clears it; revised parts never set it
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stuck_reg <= 1'b0;
    end else begin
      stuck_reg <= stuck_next;
    end
  end

  // sequencer: hold, release delay, run with watchdog
  always_comb begin
    state_next   = state_reg;
    dly_cnt_next = dly_cnt_reg;
    wd_cnt_next  = wd_cnt_reg;
    case (state_reg)
      SRSW_ST_HOLD: begin
        dly_cnt_next = CNT_ZERO;
        wd_cnt_next  = CNT_ZERO;
        if (supply_ok && !mr_active && !stuck_reg) begin
          state_next = SRSW_ST_DELAY;
        end
      end
      SRSW_ST_DELAY: begin
        wd_cnt_next = CNT_ZERO;
        if (!supply_ok || mr_active || stuck_next) begin
          state_next   = SRSW_ST_HOLD;
        end else if (dly_cnt_reg == DELAY_LAST) begin
          state_next   = SRSW_ST_RUN;
        end else begin
          dly_cnt_next = dly_cnt_reg + CNT_ONE;
        end
      end
      SRSW_ST_RUN: begin
        dly_cnt_next = CNT_ZERO;
        if (!supply_ok || mr_active) begin
          state_next  = SRSW_ST_HOLD;
        end else if (kick_edge) begin
          wd_cnt_next = CNT_ZERO;
        end else if (wd_expired) begin
          // expiry: assert for the delay, watchdog restarts after it
          state_next  = SRSW_ST_DELAY;
          wd_cnt_next = CNT_ZERO;
        end else if (HAS_WATCHDOG) begin
          wd_cnt_next = wd_cnt_reg + CNT_ONE;
        end
      end
      default: begin
        state_next = SRSW_ST_HOLD;
      end
    endcase
  end

  // sequencer registers, asserted state from the first clock
  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg   <= SRSW_ST_HOLD;
      dly_cnt_reg <= CNT_ZERO;
      wd_cnt_reg  <= CNT_ZERO;
    end else begin
      state_reg   <= state_next;
      dly_cnt_reg <= dly_cnt_next;
      wd_cnt_reg  <= wd_cnt_next;
    end
  end

  // output pins; registered from the next state, so outputs change in the same cycle as the state
  always_comb begin
    out_next.reset_n = (state_next == SRSW_ST_RUN);
    // open drain only pulls low, push-pull always drives
    out_next.reset_n_oe = OPEN_DRAIN ? !out_next.reset_n : 1'b1;
    // complement output, held low when absent
    out_next.reset_h = HAS_ACTIVE_HIGH && !out_next.reset_n;
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      out_reg <= '{reset_n: 1'b0, reset_n_oe: 1'b1,
                   reset_h: HAS_ACTIVE_HIGH};
    end else begin
      out_reg <= out_next;
    end
  end

  assign reset_n_o    = out_reg.reset_n;
  assign reset_n_oe_o = out_reg.reset_n_oe;
  assign reset_o      = out_reg.reset_h;

  // durations are per-variant parameters

endmodule

/* srsw_checker.sv */
`timescale 1ns/1ps
module srsw_checker #(
  parameter int unsigned RELEASE_DELAY_CYC = 20,
  parameter int unsigned WD_TIMEOUT_CYC    = 50
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic supply_good_i,
  input wire logic manual_reset_request_n_i,
  input wire logic watchdog_kick_input_i,
  input wire logic reset_n_o,
  input wire logic reset_n_oe_o,
  input wire logic reset_o
);
  logic [7:0] good_reg, good_next, idle_reg, idle_next;
  logic       kick_reg;
  // saturating runs: inputs good, released without a kick
  always_comb begin
    good_next = good_reg + {7'h00, good_reg != 8'hff};
    idle_next = idle_reg + {7'h00, idle_reg != 8'hff};
    if (!(supply_good_i && manual_reset_request_n_i)) good_next = 8'h00;
    if (!reset_n_o || kick_reg != watchdog_kick_input_i) idle_next = 8'h00;
  end
  always_ff @(posedge clk_sys_i) begin
    good_reg <= reset_n_i ? good_next : 8'h00;
    idle_reg <= reset_n_i ? idle_next : 8'h00;
    kick_reg <= watchdog_kick_input_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_power_up_low: assert property ($rose(reset_n_i) |-> !reset_n_o)
    else $error("reset not low at start");
  a_supply_low_holds: assert property (!supply_good_i [*5] |-> !reset_n_o)
    else $error("supply low, reset released");
  a_manual_low_holds: assert property (
    !manual_reset_request_n_i [*5] |-> !reset_n_o)
    else $error("manual low, reset released");
  a_high_complement: assert property (reset_o == !reset_n_o)
    else $error("active-high not complement");
  a_oe_push_pull: assert property (reset_n_oe_o)
    else $error("push-pull enable dropped");
  a_release_not_early: assert property (
    $rose(reset_n_o) |-> good_reg >= RELEASE_DELAY_CYC)
    else $error("release too early");
  a_release_not_late: assert property (
    good_reg == RELEASE_DELAY_CYC + 12 |-> reset_n_o)
    else $error("release too late");
  a_wd_window: assert property (idle_reg <= WD_TIMEOUT_CYC + 10 && ($fell(
    reset_n_o) && good_reg > 8 -> idle_reg >= WD_TIMEOUT_CYC - 2))
    else $error("watchdog expiry off time");
  c_release: cover property ($rose(reset_n_o));
  c_wd_expiry: cover property ($fell(reset_n_o) && good_reg > 8);
  c_manual: cover property (!manual_reset_request_n_i && supply_good_i);
endmodule

/* srsw_proc_model.sv */
`timescale 1ns/1ps
module srsw_proc_model (
  input  wire logic clk_sys_i,
  input  wire logic run_i,
  output logic      kick_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic       kick_reg = 1'b0;
  // toggle every 10 cycles, also during reset, as a bare processor would
  always_ff @(posedge clk_sys_i) begin
    cnt_reg  <= (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
    kick_reg <= kick_reg ^ (run_i && cnt_reg == 4'h9);
  end
  assign kick_o = kick_reg;
endmodule

/* srsw_supervisor_tb.sv */
`timescale 1ns/1ps
module srsw_supervisor_tb;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic good      = 1'b0;
  logic mr_n      = 1'b1;
  logic run       = 1'b1;
  logic kick, rst_n, rst_oe, rst_h;
  int   errors    = 0;
  int   cmp_count = 0;
  int   n;
  always #20 clk_sys_i = ~clk_sys_i;
  srsw_supervisor #(.HAS_ACTIVE_HIGH(1'b1), .RELEASE_DELAY_CYC(20),
    .WD_TIMEOUT_CYC(50)) DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .supply_good_i(good), .manual_reset_request_n_i(mr_n),
    .watchdog_kick_input_i(kick), .reset_n_o(rst_n),
    .reset_n_oe_o(rst_oe), .reset_o(rst_h));
  srsw_proc_model u_proc (.clk_sys_i(clk_sys_i), .run_i(run), .kick_o(kick));
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  // bounded wait for a reset level, cycles counted in n
  task automatic wait_rst(input logic lvl);
    n = 0;
    while (rst_n !== lvl && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic power_up;
    step(3);
    reset_n_i = 1'b1;
    step(2);
    chk(rst_n, 1'b0);
    chk(rst_h, 1'b1);
    good = 1'b1;
    wait_rst(1'b1);
    chk(n >= 20 && n <= 30, 1'b1);
    chk(rst_h, 1'b0);
    $display("power_up done");
  endtask
  task automatic supply_drop;
    good = 1'b0;
    step(6);
    chk(rst_n, 1'b0);
    good = 1'b1;
    step(12);
    good = 1'b0;
    step(6);
    good = 1'b1;
    wait_rst(1'b1);
    chk(n >= 20, 1'b1);
    $display("supply_drop done");
  endtask
  task automatic manual;
    mr_n = 1'b0;
    step(6);
    chk(rst_n, 1'b0);
    chk(rst_oe, 1'b1);
    mr_n = 1'b1;
    wait_rst(1'b1);
    chk(n >= 20, 1'b1);
    $display("manual done");
  endtask
  task automatic watchdog;
    step(150);
    chk(rst_n, 1'b1);
    run = 1'b0;
    wait_rst(1'b0);
    chk(n >= 38 && n <= 60, 1'b1);
    run = 1'b1;
    wait_rst(1'b1);
    chk(n >= 20 && n <= 30, 1'b1);
    $display("watchdog done");
  endtask
  // mid-run power-on reset: output drops at once, then a normal release
  task automatic reset_again;
    reset_n_i = 1'b0;
    step(1);
    chk(rst_n, 1'b0);
    step(2);
    reset_n_i = 1'b1;
    wait_rst(1'b1);
    chk(n >= 20 && n <= 30, 1'b1);
    $display("reset_again done");
  endtask
  initial begin
    power_up();
    supply_drop();
    manual();
    watchdog();
    reset_again();
    print_verdict();
  end
endmodule
bind srsw_supervisor srsw_checker #(.RELEASE_DELAY_CYC(RELEASE_DELAY_CYC),
  .WD_TIMEOUT_CYC(WD_TIMEOUT_CYC)) u_chk (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .supply_good_i(supply_good_i),
  .manual_reset_request_n_i(manual_reset_request_n_i),
  .watchdog_kick_input_i(watchdog_kick_input_i), .reset_n_o(reset_n_o),
  .reset_n_oe_o(reset_n_oe_o), .reset_o(reset_o));
